// ==== rtl/rdsc_host.sv ====
// Host end: APB-controlled serial master for the relay driver link.
// Assumes an APB master on clk; link partner is the device end.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "rdsc_consts.svh"
module rdsc_host (
	// System
	input wire logic clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Link
	rdsc_link_if.host link
);
	localparam logic [5:0] HALF = 6'(`RDSC_CYC_UP(`RDSC_SCLK_HALF_NS));
	localparam logic [5:0] LEAD = 6'(`RDSC_CYC_UP(`RDSC_LEAD_NS));
	localparam logic [5:0] LAG = 6'(`RDSC_CYC_UP(`RDSC_LAG_NS));
	localparam logic [5:0] GAP = 6'(`RDSC_CYC_UP(`RDSC_TD_NS));
	rdsc_pkg::rdsc_hstate_t st_q, st_d;
	logic [5:0] tmr_q, tmr_d, bits_q, bits_d;
	logic sclk_q, sclk_d, cs_q, cs_d, first_q, first_d;
	logic [15:0] tx_q, tx_d, rx_q, rx_d, rxSh_q, rxSh_d;
	logic [15:0] cur_q, cur_d, prev_q, prev_d;
	logic [2:0] sync_q, sync_d;
	logic soF_q, soF_d;
	logic ist_q, ist_d, msk_q, msk_d, irq_q, irq_d;
	logic [31:0] rd_q, rd_d;
	logic rdy_q, rdy_d, err_q, err_d;
	logic wrEn, done, mapped;
	logic [5:0] len;

	assign link.sclk = sclk_q;
	assign link.chipSelectN = cs_q;
	assign link.si = tx_q[15];
	assign prdata = rd_q;
	assign pready = rdy_q;
	assign pslverr = err_q;
	assign irq = irq_q;

	// Serial output synchroniser, filtered as on the device
	always_comb
	begin
		sync_d = {sync_q[1:0], link.soLine};
		soF_d = (sync_q[2] == sync_q[1]) ? sync_q[1] : soF_q;
	end

	// APB slave: one wait-free access, answer ready in access phase
	always_comb
	begin
		wrEn = psel & penable & pwrite & rdy_q;
		mapped = paddr == `RDSC_A_CMD || paddr == `RDSC_A_RX
			|| paddr == `RDSC_A_STAT || paddr == `RDSC_A_IST
			|| paddr == `RDSC_A_IMSK || paddr == `RDSC_A_PREV;
		rdy_d = psel & ~penable;
		err_d = psel & ~penable & ~mapped;
		rd_d = 32'h00000000;
		unique case (paddr)
			`RDSC_A_CMD: rd_d = {16'h0000, cur_q};
			`RDSC_A_RX: rd_d = {16'h0000, rx_q};
			`RDSC_A_STAT: rd_d = {31'h0, st_q != rdsc_pkg::RDSC_H_IDLE};
			`RDSC_A_IST: rd_d = {31'h0, ist_q};
			`RDSC_A_IMSK: rd_d = {31'h0, msk_q};
			`RDSC_A_PREV: rd_d = {16'h0000, prev_q}; // see R11
			default: rd_d = 32'h00000000;
		endcase
		if (!(psel & ~penable))
		begin
			rd_d = 32'h00000000;
		end
	end

	// Frame sequencer
	always_comb
	begin
		st_d = st_q;
		tmr_d = (tmr_q != 6'h00) ? tmr_q - 6'h01 : tmr_q;
		bits_d = bits_q;
		sclk_d = sclk_q;
		cs_d = cs_q;
		first_d = first_q;
		tx_d = tx_q;
		rx_d = rx_q;
		rxSh_d = rxSh_q;
		cur_d = cur_q;
		prev_d = prev_q;
		done = 1'b0;
		len = pwdata[`RDSC_LEN_LSB +: 6];
		unique case (st_q)
			rdsc_pkg::RDSC_H_IDLE:
			begin
				// Commands written while busy are dropped
				if (wrEn && paddr == `RDSC_A_CMD)
				begin
					tx_d = pwdata[15:0]; // see R12
					prev_d = cur_q; // see R11
					cur_d = pwdata[15:0];
					bits_d = (len == 6'h00) ? `RDSC_LEN_DEF : len;
					cs_d = 1'b0;
					tmr_d = LEAD;
					first_d = 1'b1;
					st_d = rdsc_pkg::RDSC_H_LEAD;
				end
			end
			rdsc_pkg::RDSC_H_LEAD:
			begin
				if (tmr_q == 6'h00)
				begin
					tmr_d = HALF;
					st_d = rdsc_pkg::RDSC_H_SHIFT;
				end
			end
			rdsc_pkg::RDSC_H_SHIFT:
			begin
				if (tmr_q == 6'h00)
				begin
					tmr_d = HALF;
					sclk_d = ~sclk_q;
					if (!sclk_q)
					begin
						// Next input bit changes after the rising edge
						first_d = 1'b0;
						if (!first_q)
						begin
							tx_d = {tx_q[14:0], 1'b0};
						end
					end
					else
					begin
						rxSh_d = {rxSh_q[14:0], soF_q};
						bits_d = bits_q - 6'h01;
						if (bits_q == 6'h01)
						begin
							tmr_d = LAG;
							st_d = rdsc_pkg::RDSC_H_LAG;
						end
					end
				end
			end
			rdsc_pkg::RDSC_H_LAG:
			begin
				if (tmr_q == 6'h00)
				begin
					cs_d = 1'b1; // see R14
					rx_d = rxSh_q;
					done = 1'b1;
					tmr_d = GAP;
					st_d = rdsc_pkg::RDSC_H_GAP;
				end
			end
			rdsc_pkg::RDSC_H_GAP:
			begin
				if (tmr_q == 6'h00)
				begin
					st_d = rdsc_pkg::RDSC_H_IDLE;
				end
			end
			default: st_d = rdsc_pkg::RDSC_H_IDLE;
		endcase
	end

	// Interrupt: done is sticky, write one clears, set wins
	always_comb
	begin
		ist_d = ist_q;
		msk_d = msk_q;
		if (wrEn && paddr == `RDSC_A_IST && pwdata[0])
		begin
			ist_d = 1'b0;
		end
		if (done)
		begin
			ist_d = 1'b1;
		end
		if (wrEn && paddr == `RDSC_A_IMSK)
		begin
			msk_d = pwdata[0];
		end
		irq_d = ist_d & msk_d;
	end

	// Registers
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			st_q <= rdsc_pkg::RDSC_H_IDLE;
			tmr_q <= 6'h00;
			bits_q <= 6'h00;
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			first_q <= 1'b0;
			tx_q <= 16'h0000;
			rx_q <= 16'h0000;
			rxSh_q <= 16'h0000;
			cur_q <= 16'h0000;
			prev_q <= 16'h0000;
			sync_q <= 3'h0;
			soF_q <= 1'b0;
			ist_q <= 1'b0;
			msk_q <= 1'b0;
			irq_q <= 1'b0;
			rd_q <= 32'h00000000;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			bits_q <= bits_d;
			sclk_q <= sclk_d;
			cs_q <= cs_d;
			first_q <= first_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			rxSh_q <= rxSh_d;
			cur_q <= cur_d;
			prev_q <= prev_d;
			sync_q <= sync_d;
			soF_q <= soF_d;
			ist_q <= ist_d;
			msk_q <= msk_d;
			irq_q <= irq_d;
			rd_q <= rd_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
		end
	end
endmodule : rdsc_host

// ==== rtl/rdsc_consts.svh ====
// Constants of the relay driver serial command link, both ends.
// Assumes a 125 MHz system clock on both ends.
`ifndef RDSC_CONSTS_SVH
`define RDSC_CONSTS_SVH
// Frame layout
`define RDSC_FRAME_BITS 16
`define RDSC_CNT_MIN 5'h10
`define RDSC_CNT_WRAP 5'h17
`define RDSC_PFX_WRITE 2'b10
`define RDSC_PFX_READ 2'b01
`define RDSC_PFX_BADW 2'b11
`define RDSC_TAIL_DIAG 2'b01
`define RDSC_TAIL_READ 2'b10
// Register map seen through the link
`define RDSC_BANK_OUT 4'h0
`define RDSC_BANK_CFG 4'h1
`define RDSC_BANK_INSTRUCTION_REGISTER 4'h2
`define RDSC_SEL_ZERO 2'b00
`define RDSC_OUT_RST 8'h00
`define RDSC_CFG_RST 32'h00000000
`define RDSC_INSTRUCTION_REGISTER_RST 8'h00
// Reply words
`define RDSC_SYNTAX_REPLY 16'hC000
`define RDSC_TER_BIT 10
// Synchroniser lane positions
`define RDSC_I_SCLK 2
`define RDSC_I_CS 1
`define RDSC_I_SI 0
// Host timing, times in ns
`define RDSC_CLK_NS 8
`define RDSC_SCLK_HALF_NS 100
`define RDSC_LEAD_NS 200
`define RDSC_LAG_NS 200
`define RDSC_TD_NS 250
`define RDSC_CYC_UP(ns) (((ns) + `RDSC_CLK_NS - 1) / `RDSC_CLK_NS)
// Host APB offsets and fields
`define RDSC_A_CMD 8'h00
`define RDSC_A_RX 8'h04
`define RDSC_A_STAT 8'h08
`define RDSC_A_IST 8'h0C
`define RDSC_A_IMSK 8'h10
`define RDSC_A_PREV 8'h14
`define RDSC_LEN_LSB 16
`define RDSC_LEN_DEF 6'h10
`endif

// ==== rtl/rdsc_pkg.sv ====
// Types shared by both ends of the relay driver serial link.
// Assumes nothing beyond a SystemVerilog compiler.
package rdsc_pkg;
	// Which answer the device sends in the next frame
	typedef enum logic [2:0] {
		RDSC_RPL_RESET = 3'h0,
		RDSC_RPL_DIAG = 3'h1,
		RDSC_RPL_TERR = 3'h3,
		RDSC_RPL_SYNTAX = 3'h2,
		RDSC_RPL_READ = 3'h6
	} rdsc_reply_t;
	// Host frame sequencer
	typedef enum logic [2:0] {
		RDSC_H_IDLE = 3'h0,
		RDSC_H_LEAD = 3'h1,
		RDSC_H_SHIFT = 3'h3,
		RDSC_H_LAG = 3'h2,
		RDSC_H_GAP = 3'h6
	} rdsc_hstate_t;
endpackage : rdsc_pkg

// ==== rtl/rdsc_link_if.sv ====
// Serial link between the relay driver and its controller.
// Assumes the bench instantiates it and joins both ends.
`timescale 1ns/1ps
interface rdsc_link_if;
	logic sclk;
	logic chipSelectN;
	logic si;
	logic so;
	logic soOe;
	logic soLine;
	// Released line shows the inverse of the last bit; late samples show
	assign soLine = soOe ? so : ~so;
	modport device (input sclk, input chipSelectN, input si,
		output so, output soOe);
	modport host (output sclk, output chipSelectN, output si,
		input soLine);
endinterface : rdsc_link_if

// ==== rtl/rdsc_device.sv ====
// Device end: serial command interpreter of a relay driver.
// Assumes link pins asynchronous to clk, slower than clk / 6.
//
// Contract
// R1: Answer comes in the following frame only
// R2: Clock count not 16+8n gives error reply
// R3: After reset send special reply frame
// R4: Prefix 11 is a syntax error
// R5: Read prefix 00 is a syntax error
// R6: Reserved register access is a syntax error
// R7: Diagnosis request 0...01 returns diagnosis word; the code checks only for a 00 or 01 prefix and a 01 tail
// R8: Write 10 stores data, returns diagnosis
// R9: Read frame is 01, selects, 10 tail
// R10: Read reply echoes selects and content
// R11: Master remembers its previous command
// R12: Commands on input, replies on output
// R13: Reply MSB first, output off when deselected
// R14: Chip select rising edge accepts the frame
// R15: First reply after reset: error flag, instruction
// R16: Error flag reports previous transfer failure
// R17: Sample on falling, update after rising
// R18: Bad frames leave registers unchanged
`timescale 1ns/1ps
`include "rdsc_consts.svh"
module rdsc_device (
	// System
	input wire logic clk,
	input wire logic reset_n,
	// Link
	rdsc_link_if.device link,
	// Software reset request, one cycle
	input wire logic softReset,
	// Diagnosis sources
	input wire logic undervoltage,
	input wire logic lowSupply,
	input wire logic [1:0] opMode,
	input wire logic openLoadOff,
	input wire logic [7:0] channelError,
	// Register contents
	output logic [7:0] outControl,
	output logic [31:0] configBank,
	output logic [7:0] instructionReg
);
	logic [2:0] s1_q, s2_q, s3_q, filt_q;
	logic [2:0] s1_d, s2_d, s3_d, filt_d;
	logic [15:0] shift_q, shift_d;
	logic [4:0] cnt_q, cnt_d;
	logic so_q, so_d, soOe_q, soOe_d;
	rdsc_pkg::rdsc_reply_t kind_q, kind_d;
	logic [15:0] readWord_q, readWord_d;
	logic [7:0] out_q, out_d, instruction_register_q, instruction_register_d;
	logic [31:0] cfg_q, cfg_d;
	logic csFall, csRise, sclkFall, sclkRise, active;
	logic [15:0] diagWord, reply;
	logic [1:0] pfx, tail, sel;
	logic [3:0] bank;
	logic frameOk, addrOk, readable;
	logic [7:0] readByte;

	assign link.so = so_q;
	assign link.soOe = soOe_q;
	assign outControl = out_q;
	assign configBank = cfg_q;
	assign instructionReg = instruction_register_q;

	// Pin synchroniser; a change counts when stages two and three agree
	always_comb
	begin
		s1_d = {link.sclk, link.chipSelectN, link.si};
		s2_d = s1_q;
		s3_d = s2_q;
		filt_d = (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
	end

	// Edges of the filtered link signals
	always_comb
	begin
		active = ~filt_q[`RDSC_I_CS];
		csFall = filt_q[`RDSC_I_CS] & ~filt_d[`RDSC_I_CS];
		csRise = ~filt_q[`RDSC_I_CS] & filt_d[`RDSC_I_CS];
		sclkFall = active & filt_q[`RDSC_I_SCLK] & ~filt_d[`RDSC_I_SCLK];
		sclkRise = active & ~filt_q[`RDSC_I_SCLK] & filt_d[`RDSC_I_SCLK];
	end

	// Frame fields of the word shifted in
	always_comb
	begin
		pfx = shift_q[15:14];
		bank = shift_q[13:10];
		sel = shift_q[9:8];
		tail = shift_q[1:0];
		frameOk = (cnt_q == `RDSC_CNT_MIN); // see R2 see R16
		addrOk = (bank == `RDSC_BANK_OUT && sel == `RDSC_SEL_ZERO)
			|| bank == `RDSC_BANK_CFG;
		readable = addrOk
			|| (bank == `RDSC_BANK_INSTRUCTION_REGISTER && sel == `RDSC_SEL_ZERO);
		if (bank == `RDSC_BANK_OUT)
		begin
			readByte = out_q;
		end
		else if (bank == `RDSC_BANK_CFG)
		begin
			readByte = cfg_q[sel * 8 +: 8];
		end
		else
		begin
			readByte = instruction_register_q;
		end
	end

	// Reply word picked by what the previous frame asked for
	always_comb
	begin
		diagWord = {1'b0, undervoltage, lowSupply, opMode, 1'b0, 1'b0,
			openLoadOff, channelError}; // see R7
		reply = diagWord;
		unique case (kind_q)
			rdsc_pkg::RDSC_RPL_RESET:
			begin
				reply = {diagWord[15:8], instruction_register_q}; // see R15
				reply[`RDSC_TER_BIT] = 1'b1; // see R3
			end
			rdsc_pkg::RDSC_RPL_DIAG: reply = diagWord;
			rdsc_pkg::RDSC_RPL_TERR: reply[`RDSC_TER_BIT] = 1'b1; // see R16
			rdsc_pkg::RDSC_RPL_SYNTAX: reply = `RDSC_SYNTAX_REPLY;
			rdsc_pkg::RDSC_RPL_READ: reply = readWord_q; // see R10
		endcase
	end

	// Shifting, decoding and register writes
	always_comb
	begin
		shift_d = shift_q;
		cnt_d = cnt_q;
		so_d = so_q;
		soOe_d = soOe_q;
		kind_d = kind_q;
		readWord_d = readWord_q;
		out_d = out_q;
		cfg_d = cfg_q;
		instruction_register_d = instruction_register_q;
		if (softReset)
		begin
			// Software reset behaves like power-on; output released
			soOe_d = 1'b0;
			kind_d = rdsc_pkg::RDSC_RPL_RESET; // see R3
			out_d = `RDSC_OUT_RST;
			cfg_d = `RDSC_CFG_RST;
			instruction_register_d = `RDSC_INSTRUCTION_REGISTER_RST;
		end
		else if (csFall)
		begin
			// Reply loaded now holds the previous frame's answer
			shift_d = reply; // see R1
			so_d = reply[15]; // see R13
			soOe_d = 1'b1;
			cnt_d = 5'h00;
		end
		else if (sclkFall)
		begin
			// One register shifts input in and reply out
			shift_d = {shift_q[14:0], filt_q[`RDSC_I_SI]}; // see R17 see R12
			cnt_d = (cnt_q == `RDSC_CNT_WRAP) ? `RDSC_CNT_MIN
				: cnt_q + 5'h01;
		end
		else if (sclkRise)
		begin
			so_d = shift_q[15]; // see R17 see R13
		end
		else if (csRise)
		begin
			soOe_d = 1'b0; // see R13
			// Only this edge commits the frame
			if (!frameOk)
			begin
				kind_d = rdsc_pkg::RDSC_RPL_TERR; // see R2 see R18
			end
			else if (pfx == `RDSC_PFX_WRITE)
			begin // see R14
				if (addrOk)
				begin
					kind_d = rdsc_pkg::RDSC_RPL_DIAG; // see R8
					instruction_register_d = shift_q[15:8];
					if (bank == `RDSC_BANK_OUT)
					begin
						out_d = shift_q[7:0];
					end
					else
					begin
						cfg_d[sel * 8 +: 8] = shift_q[7:0];
					end
				end
				else
				begin
					kind_d = rdsc_pkg::RDSC_RPL_SYNTAX; // see R6 see R18
				end
			end
			else if (pfx == `RDSC_PFX_BADW)
			begin
				kind_d = rdsc_pkg::RDSC_RPL_SYNTAX; // see R4
			end
			else if (tail == `RDSC_TAIL_DIAG)
			begin
				kind_d = rdsc_pkg::RDSC_RPL_DIAG; // see R7
			end
			else if (pfx == `RDSC_PFX_READ && tail == `RDSC_TAIL_READ
				&& readable)
			begin // see R9
				kind_d = rdsc_pkg::RDSC_RPL_READ;
				instruction_register_d = shift_q[15:8];
				readWord_d = {`RDSC_PFX_WRITE, bank, sel, readByte}; // see R10
			end
			else
			begin
				// Read prefix 00, bad tail or unmapped read
				kind_d = rdsc_pkg::RDSC_RPL_SYNTAX; // see R5 see R6
			end
		end
	end

	// State registers; reset reply pending after power-on
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s1_q <= 3'h2;
			s2_q <= 3'h2;
			s3_q <= 3'h2;
			filt_q <= 3'h2;
			shift_q <= 16'h0000;
			cnt_q <= 5'h00;
			so_q <= 1'b0;
			soOe_q <= 1'b0;
			kind_q <= rdsc_pkg::RDSC_RPL_RESET; // see R15
			readWord_q <= 16'h0000;
			out_q <= `RDSC_OUT_RST;
			cfg_q <= `RDSC_CFG_RST;
			instruction_register_q <= `RDSC_INSTRUCTION_REGISTER_RST;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			filt_q <= filt_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			so_q <= so_d;
			soOe_q <= soOe_d;
			kind_q <= kind_d;
			readWord_q <= readWord_d;
			out_q <= out_d;
			cfg_q <= cfg_d;
			instruction_register_q <= instruction_register_d;
		end
	end
endmodule : rdsc_device

// ==== verification/rdsc_link_asserts.sv ====
// Wire checks for the relay driver serial link.
// Assumes the bench ties it beside the link interface.
`timescale 1ns/1ps
module rdsc_link_asserts (
	// System
	input wire logic clk,
	input wire logic reset_n,
	// Link wires
	input wire logic sclk,
	input wire logic chipSelectN,
	input wire logic si,
	input wire logic so,
	input wire logic soOe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Quiet clock after select falls
	sequence s_lead;
		!sclk [*8];
	endsequence
	// Minimum high phase, the filter needs six cycles
	sequence s_half_hi;
		sclk [*6];
	endsequence
	// Minimum low phase
	sequence s_half_lo;
		!sclk [*6];
	endsequence
	AST_SCLK_IDLE: assert property (chipSelectN |-> !sclk)
		else $error("serial clock moves outside a frame");
	AST_LEAD: assert property ($fell(chipSelectN) |-> s_lead)
		else $error("serial clock starts too soon");
	AST_HALF_HI: assert property ($rose(sclk) |-> s_half_hi)
		else $error("serial clock high phase too short");
	AST_HALF_LO: assert property ($fell(sclk) |-> s_half_lo)
		else $error("serial clock low phase too short");
	AST_SI_HOLD: assert property (
		$fell(sclk) |-> $stable(si) ##1 $stable(si))
		else $error("command bit moves at the sampling edge");
	AST_SO_HOLD: assert property (
		$fell(sclk) && soOe |-> $stable(so))
		else $error("reply bit moves at the sampling edge");
	AST_SO_EN: assert property ($fell(chipSelectN) |-> ##[1:25] soOe)
		else $error("reply output not enabled in time");
	AST_SO_OFF: assert property (chipSelectN [*8] |-> !soOe)
		else $error("reply output driven while deselected");
endmodule : rdsc_link_asserts

// ==== verification/tb.sv ====
// Bench joining host and device ends of the relay driver link.
// Assumes rtl/ on the include path; the host makes the link clock.
`timescale 1ns/1ps
`include "rdsc_consts.svh"
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, configBank, rd;
	logic pready, pslverr, irq, er, softReset = 1'b0, imask = 1'b1;
	logic [7:0] outControl, instructionReg;
	logic [15:0] wireRx, wireTx, rx;
	// Diagnosis sources, a mix of ones and zeros
	logic uv = 1'b1, low = 1'b0, ol = 1'b1;
	logic [1:0] mode = 2'b10;
	logic [7:0] chErr = 8'h5A;
	int mismatches = 0;
	int check_count = 0;

	// Clock and the two ends
	always #4 clk = ~clk;
	rdsc_link_if link();
	rdsc_device i_rdsc_device (.clk(clk), .reset_n(reset_n), .link(link),
		.softReset(softReset), .undervoltage(uv), .lowSupply(low),
		.opMode(mode), .openLoadOff(ol), .channelError(chErr),
		.outControl(outControl), .configBank(configBank),
		.instructionReg(instructionReg));
	rdsc_host i_rdsc_host (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link(link));
	rdsc_link_asserts i_rdsc_link_asserts (.clk(clk), .reset_n(reset_n),
		.sclk(link.sclk), .chipSelectN(link.chipSelectN), .si(link.si),
		.so(link.so), .soOe(link.soOe));

	// Capture both data lines at the serial sampling edge
	always @(negedge link.sclk)
		if (!link.chipSelectN)
		begin
			wireRx <= {wireRx[14:0], link.soLine};
			wireTx <= {wireTx[14:0], link.si};
		end

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Expected diagnosis word from the source levels
	function automatic logic [15:0] diag(input logic transfer_error_flag);
		return {1'b0, uv, low, mode, transfer_error_flag, 1'b0, ol, chErr};
	endfunction : diag

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		check(pready, 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Send one command, wait for done, fetch the reply of this frame
	task automatic frame(input logic [15:0] cmd, input logic [5:0] len);
		int n;
		n = 0;
		apb(1'b1, `RDSC_A_CMD, {10'h0, len, cmd});
		do
		begin
			apb(1'b0, `RDSC_A_IST, 32'h0);
			n++;
		end
		while (rd[0] !== 1'b1 && n < 400);
		check(rd[0], 1'b1);
		check(irq, imask);
		apb(1'b0, `RDSC_A_RX, 32'h0);
		rx = rd[15:0];
		apb(1'b1, `RDSC_A_IST, 32'h1);
		check(irq, 1'b0);
		n = 0;
		do
		begin
			apb(1'b0, `RDSC_A_STAT, 32'h0);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 400);
		check(rd[0], 1'b0);
		if (len == 6'h10)
		begin
			check(wireRx, rx);
			check(wireTx, cmd);
		end
	endtask : frame

	// Reset reply, then diagnosis answer one frame late
	task automatic t_reset();
		check(outControl, 8'h00);
		check(configBank, 32'h0);
		frame(16'h0001, 6'h10);
		check(rx, diag(1'b1) & 16'hFF00);
		frame(16'h7FFD, 6'h10);
		check(rx, diag(1'b0));
		$display("reset reply test done");
	endtask : t_reset

	// Writes then back to back reads
	task automatic t_wr();
		frame(16'h80A5, 6'h10);
		check(rx, diag(1'b0));
		frame(16'h863C, 6'h10);
		check(rx, diag(1'b0));
		check(outControl, 8'hA5);
		frame(16'h46FE, 6'h10);
		check(rx, diag(1'b0));
		check(configBank[23:16], 8'h3C);
		check(instructionReg, 8'h46);
		frame(16'h40FE, 6'h10);
		check(rx, 16'h863C);
		frame(16'h0001, 6'h10);
		check(rx, 16'h80A5);
		apb(1'b0, `RDSC_A_PREV, 32'h0);
		check(rd, 32'h000040FE);
		$display("write read test done");
	endtask : t_wr

	// Bad prefixes and reserved places give the syntax reply
	task automatic t_syntax();
		logic [15:0] bad [7] = '{16'hC0FF, 16'h00FE, 16'h8CFF, 16'h81FF,
			16'h88FF, 16'h54FE, 16'h49FE};
		foreach (bad[i])
		begin
			frame(bad[i], 6'h10);
			frame(16'h0001, 6'h10);
			check(rx, `RDSC_SYNTAX_REPLY);
			check(outControl, 8'hA5);
		end
		$display("syntax test done");
	endtask : t_syntax

	// Wrong clock counts flag an error, 24 clocks do not
	task automatic t_count();
		frame(16'h80FF, 6'h0C);
		frame(16'h0001, 6'h10);
		check(rx, diag(1'b1));
		check(outControl, 8'hA5);
		frame(16'h80FF, 6'h11);
		frame(16'h0001, 6'h10);
		check(rx, diag(1'b1));
		check(outControl, 8'hA5);
		frame(16'h0001, 6'h18);
		frame(16'h0001, 6'h10);
		check(rx[10], 1'b0);
		$display("clock count test done");
	endtask : t_count

	// Unmapped address, then a masked done event
	task automatic t_misc();
		apb(1'b0, 8'h18, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		imask = 1'b0;
		apb(1'b1, `RDSC_A_IMSK, 32'h0);
		frame(16'h0001, 6'h10);
		check(rx, diag(1'b0));
		$display("bus and mask test done");
	endtask : t_misc

	// Software reset clears registers and repeats the reset reply
	task automatic t_soft();
		softReset <= 1'b1;
		@(posedge clk);
		softReset <= 1'b0;
		@(posedge clk);
		check(outControl, 8'h00);
		frame(16'h0001, 6'h10);
		check(rx, diag(1'b1) & 16'hFF00);
		$display("software reset test done");
	endtask : t_soft

	// Counts, verdict and stop
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// Main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		apb(1'b1, `RDSC_A_IMSK, 32'h1);
		t_reset();
		t_wr();
		t_syntax();
		t_count();
		t_misc();
		t_soft();
		end_of_test();
	end

	// Watchdog, well above the length of all frames
	initial
	begin
		repeat (90000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule : tb
